// [calje_core.sv]
// Notes on behaviour
// RULE1 - Add registers, one cycle, flags Z C N V H.
// RULE2 - Subtract registers, one cycle, flags Z C N V H.
// RULE3 - Subtract immediate, one cycle, flags Z C N V H.
// RULE4 - Word add immediate, two cycles, Z C N V S.
// RULE5 - Word subtract immediate, two cycles, Z C N V S.
// RULE6 - Logic ops one cycle, Z N V, carry kept.
// RULE7 - Invert from 0xFF, negate from 0x00, carry touched.
// RULE8 - Clear bits ANDs inverted mask; set ORs mask.
// RULE9 - Increment or decrement, one cycle, carry kept.
// RULE10 - Zero test ANDs register with itself.
// RULE11 - Register clear XORs register with itself.
// RULE12 - Multiplies write R1:R0, two cycles, Z C.
// RULE13 - Fractional multiplies shift product left one.
// RULE14 - Relative jump: PC plus offset plus one, two cycles.
// RULE15 - Indirect jump loads PC from Z, two cycles.
// RULE16 - Absolute jump three cycles, absolute entry four.
// RULE17 - Relative entry: PC plus offset plus one, three.
// RULE18 - Indirect entry loads PC from Z, three cycles.
// RULE19 - Entries push return address; exits pop in four.
// RULE20 - Interrupt exit also sets global interrupt enable.
// RULE21 - All-ones register load leaves flags unchanged.
`timescale 1ns/1ps
`default_nettype none
module calje_core
  import calje_pkg::*;
#(
  parameter int PC_W = 16,
  parameter int OFS_W = 12
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Request handshake
  input wire logic start_in,
  input wire calje_op_e op_in,
  output logic ready_out,
  output logic busy_out,
  output logic done_out,
  // Operands
  input wire logic [7:0] rd_val_in,
  input wire logic [7:0] rr_val_in,
  input wire logic [7:0] imm_in,
  input wire logic [15:0] pair_in,
  input wire logic [7:0] status_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [PC_W-1:0] ptr_z_in,
  input wire logic [OFS_W-1:0] rel_offset_in,
  input wire logic [PC_W-1:0] target_in,
  input wire logic [PC_W-1:0] stack_top_in,
  // Results
  output logic rd_we_out,
  output logic [7:0] rd_data_out,
  output logic pair_we_out,
  output logic prod_we_out,
  output logic [15:0] pair_data_out,
  output logic status_we_out,
  output logic [7:0] status_out,
  output logic pc_we_out,
  output logic [PC_W-1:0] pc_out,
  output logic push_out,
  output logic [PC_W-1:0] push_data_out,
  output logic pop_out
);

  localparam logic [PC_W-1:0] STEP_SHORT = PC_W'(PC_STEP_SHORT);
  localparam logic [PC_W-1:0] STEP_LONG = PC_W'(PC_STEP_LONG);

  calje_state_e state_reg, state_next;
  calje_op_e op_reg, op_next;
  logic [2:0] count_reg, count_next;
  logic rd_we_reg, rd_we_next, pair_we_reg, pair_we_next;
  logic prod_we_reg, prod_we_next, st_we_reg, st_we_next;
  logic pc_we_reg, pc_we_next, push_reg, push_next, pop_reg, pop_next;
  logic [7:0] rd_data_reg, rd_data_next, status_reg, status_next, fl;
  logic [15:0] pair_data_reg, pair_data_next;
  logic [PC_W-1:0] pc_reg, pc_next, push_data_reg, push_data_next;
  logic accept, done;
  logic [7:0] op_a, op_b, res8, log8;
  logic cin, is_sub, cout, hc, v_ar;
  logic [8:0] sum9;
  logic [4:0] nib5;
  logic [16:0] w17;
  logic [15:0] w16, prod16, mres;
  logic sa, sb, is_frac;
  logic [8:0] ea, eb;
  logic signed [17:0] prod18;
  logic [PC_W-1:0] pc_rel;

  // Cycle count of each operation; everything not listed takes one cycle.
  function automatic logic [2:0] op_cycles(input calje_op_e op);
    case (op)
      OP_WORD_IMMEDIATE_PLUS, OP_WORD_IMMEDIATE_MINUS, OP_PRODUCT_UNSIGNED,
      OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_BY_UNSIGNED, OP_FRACTIONAL_PRODUCT_UNSIGNED,
      OP_FRACTIONAL_PRODUCT_SIGNED, OP_FRACTIONAL_PRODUCT_MIXED,
      OP_RELATIVE_JUMP, OP_INDIRECT_JUMP: op_cycles = CYC_TWO; // RULE4 RULE5 RULE12 RULE14 RULE15
      OP_ABSOLUTE_JUMP, OP_RELATIVE_SUBROUTINE_ENTRY,
      OP_INDIRECT_SUBROUTINE_ENTRY: op_cycles = CYC_THREE; // RULE16 RULE17 RULE18
      OP_ABSOLUTE_SUBROUTINE_ENTRY, OP_SUBROUTINE_EXIT,
      OP_INTERRUPT_EXIT: op_cycles = CYC_FOUR; // RULE16 RULE19
      default: op_cycles = CYC_ONE;
    endcase
  endfunction

  // Zero, negative, overflow and their sign from a byte result.
  function automatic logic [7:0] flags_znv(input logic [7:0] f, input logic [7:0] r,
                                           input logic v);
    logic [7:0] o;
    o = f;
    o[FLAG_Z] = (r == BYTE_ZERO);
    o[FLAG_N] = r[BYTE_MSB];
    o[FLAG_V] = v;
    o[FLAG_S] = r[BYTE_MSB] ^ v;
    return o;
  endfunction

  // Operand selection lets every byte add and subtract share one adder.
  always_comb begin
    op_a = rd_val_in;
    op_b = rr_val_in;
    cin = 1'b0;
    is_sub = 1'b0;
    case (op_in)
      OP_ADC: cin = status_in[FLAG_C];
      OP_SUB: is_sub = 1'b1;
      OP_MINUS_IMMEDIATE: begin
        is_sub = 1'b1;
        op_b = imm_in;
      end
      OP_MINUS_WITH_BORROW_REGS: begin
        is_sub = 1'b1;
        cin = status_in[FLAG_C];
      end
      OP_MINUS_WITH_BORROW_IMMEDIATE: begin
        is_sub = 1'b1;
        op_b = imm_in;
        cin = status_in[FLAG_C];
      end
      OP_BITWISE_INVERT: begin
        is_sub = 1'b1;
        op_a = BYTE_ONES; // RULE7
        op_b = rd_val_in;
      end
      OP_TWOS_INVERT: begin
        is_sub = 1'b1;
        op_a = BYTE_ZERO; // RULE7
        op_b = rd_val_in;
      end
      OP_INC: op_b = BYTE_ONE; // RULE9
      OP_MINUS_ONE: begin
        is_sub = 1'b1;
        op_b = BYTE_ONE; // RULE9
      end
      default: begin
      end
    endcase
  end

  // Logical results, including the self-referencing test and clear forms.
  always_comb begin
    case (op_in)
      OP_AND: log8 = rd_val_in & rr_val_in; // RULE6
      OP_MASK_IMMEDIATE: log8 = rd_val_in & imm_in;
      OP_OR: log8 = rd_val_in | rr_val_in;
      OP_MERGE_IMMEDIATE, OP_SET_BITS_MASKED: log8 = rd_val_in | imm_in; // RULE8
      OP_XOR_REGS: log8 = rd_val_in ^ rr_val_in;
      OP_CLEAR_BITS_MASKED: log8 = rd_val_in & (BYTE_ONES - imm_in); // RULE8
      OP_ZERO_MINUS_CHECK: log8 = rd_val_in & rd_val_in; // RULE10
      OP_ZERO_REGISTER: log8 = rd_val_in ^ rd_val_in; // RULE11
      default: log8 = rd_val_in;
    endcase
  end

  // Byte adder with nibble carry, used for H, and overflow per direction.
  always_comb begin
    if (is_sub) begin
      sum9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
      nib5 = {1'b0, op_a[NIB_W-1:0]} - {1'b0, op_b[NIB_W-1:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
      nib5 = {1'b0, op_a[NIB_W-1:0]} + {1'b0, op_b[NIB_W-1:0]} + {4'h0, cin};
    end
    res8 = sum9[BYTE_MSB:0];
    cout = sum9[BYTE_MSB+1];
    hc = nib5[NIB_W];
    if (is_sub) begin
      v_ar = (op_a[BYTE_MSB] != op_b[BYTE_MSB]) && (res8[BYTE_MSB] != op_a[BYTE_MSB]);
    end else begin
      v_ar = (op_a[BYTE_MSB] == op_b[BYTE_MSB]) && (res8[BYTE_MSB] != op_a[BYTE_MSB]);
    end
  end

  // Word adder on the register pair with a zero-extended immediate.
  always_comb begin
    if (op_in == OP_WORD_IMMEDIATE_MINUS) begin
      w17 = {1'b0, pair_in} - {9'h000, imm_in};
    end else begin
      w17 = {1'b0, pair_in} + {9'h000, imm_in};
    end
    w16 = w17[WORD_MSB:0];
  end

  // Multiplier; operands are sign-extended only where the variant is signed.
  always_comb begin
    sa = (op_in == OP_PRODUCT_SIGNED) || (op_in == OP_PRODUCT_SIGNED_BY_UNSIGNED) ||
         (op_in == OP_FRACTIONAL_PRODUCT_SIGNED) || (op_in == OP_FRACTIONAL_PRODUCT_MIXED);
    sb = (op_in == OP_PRODUCT_SIGNED) || (op_in == OP_FRACTIONAL_PRODUCT_SIGNED);
    is_frac = (op_in == OP_FRACTIONAL_PRODUCT_UNSIGNED) ||
              (op_in == OP_FRACTIONAL_PRODUCT_SIGNED) || (op_in == OP_FRACTIONAL_PRODUCT_MIXED);
    ea = {sa & rd_val_in[BYTE_MSB], rd_val_in};
    eb = {sb & rr_val_in[BYTE_MSB], rr_val_in};
    prod18 = $signed(ea) * $signed(eb);
    prod16 = prod18[WORD_MSB:0];
    mres = is_frac ? {prod16[WORD_MSB-1:0], 1'b0} : prod16; // RULE13
  end

  // Relative target; the offset is signed and counts from the next word.
  assign pc_rel = pc_in + {{(PC_W-OFS_W){rel_offset_in[OFS_W-1]}}, rel_offset_in} + STEP_SHORT;

  // Handshake: a new request may be taken in the cycle that finishes the last.
  assign done = (state_reg == ST_BUSY) && (count_reg == CYC_ONE);
  assign ready_out = (state_reg == ST_IDLE) || done;
  assign accept = start_in && ready_out;

  // Sequencer and result capture. Results are computed on the request cycle
  // and held in registers until the count runs out, so the partner may change
  // the operands and the register file meanwhile.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    op_next = op_reg;
    rd_we_next = rd_we_reg;
    rd_data_next = rd_data_reg;
    pair_we_next = pair_we_reg;
    prod_we_next = prod_we_reg;
    pair_data_next = pair_data_reg;
    st_we_next = st_we_reg;
    status_next = status_reg;
    pc_we_next = pc_we_reg;
    pc_next = pc_reg;
    push_next = push_reg;
    push_data_next = push_data_reg;
    pop_next = pop_reg;
    fl = status_in;
    if (done) begin
      state_next = ST_IDLE;
      count_next = CYC_ZERO;
    end else if (state_reg == ST_BUSY) begin
      count_next = count_reg - CYC_ONE;
    end
    if (accept) begin
      state_next = ST_BUSY;
      count_next = op_cycles(op_in);
      op_next = op_in;
      rd_we_next = 1'b0;
      pair_we_next = 1'b0;
      prod_we_next = 1'b0;
      st_we_next = 1'b1;
      pc_we_next = 1'b0;
      push_next = 1'b0;
      pop_next = 1'b0;
      case (op_in)
        OP_ADD, OP_ADC, OP_SUB, OP_MINUS_IMMEDIATE, OP_MINUS_WITH_BORROW_REGS,
        OP_MINUS_WITH_BORROW_IMMEDIATE, OP_TWOS_INVERT: begin
          rd_we_next = 1'b1;
          rd_data_next = res8; // RULE1 RULE2 RULE3 RULE7
          fl = flags_znv(status_in, res8, v_ar);
          fl[FLAG_C] = cout;
          fl[FLAG_H] = hc;
        end
        OP_BITWISE_INVERT: begin
          rd_we_next = 1'b1;
          rd_data_next = res8;
          fl = flags_znv(status_in, res8, 1'b0);
          fl[FLAG_C] = 1'b1; // RULE7
        end
        OP_INC, OP_MINUS_ONE: begin
          rd_we_next = 1'b1;
          rd_data_next = res8;
          fl = flags_znv(status_in, res8, v_ar); // RULE9
        end
        OP_AND, OP_MASK_IMMEDIATE, OP_OR, OP_MERGE_IMMEDIATE, OP_XOR_REGS,
        OP_SET_BITS_MASKED, OP_CLEAR_BITS_MASKED, OP_ZERO_MINUS_CHECK,
        OP_ZERO_REGISTER: begin
          rd_we_next = 1'b1;
          rd_data_next = log8;
          fl = flags_znv(status_in, log8, 1'b0); // RULE6 RULE8 RULE10 RULE11
        end
        OP_ALL_ONES_REGISTER: begin
          rd_we_next = 1'b1;
          rd_data_next = BYTE_ONES;
          st_we_next = 1'b0; // RULE21
        end
        OP_WORD_IMMEDIATE_PLUS, OP_WORD_IMMEDIATE_MINUS: begin
          pair_we_next = 1'b1;
          pair_data_next = w16; // RULE4 RULE5
          fl[FLAG_Z] = (w16 == WORD_ZERO);
          fl[FLAG_N] = w16[WORD_MSB];
          if (op_in == OP_WORD_IMMEDIATE_PLUS) begin
            fl[FLAG_V] = ~pair_in[WORD_MSB] & w16[WORD_MSB];
            fl[FLAG_C] = pair_in[WORD_MSB] & ~w16[WORD_MSB];
          end else begin
            fl[FLAG_V] = pair_in[WORD_MSB] & ~w16[WORD_MSB];
            fl[FLAG_C] = ~pair_in[WORD_MSB] & w16[WORD_MSB];
          end
          fl[FLAG_S] = fl[FLAG_N] ^ fl[FLAG_V];
        end
        OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED, OP_PRODUCT_SIGNED_BY_UNSIGNED,
        OP_FRACTIONAL_PRODUCT_UNSIGNED, OP_FRACTIONAL_PRODUCT_SIGNED,
        OP_FRACTIONAL_PRODUCT_MIXED: begin
          prod_we_next = 1'b1;
          pair_data_next = mres; // RULE12 RULE13
          fl[FLAG_Z] = (mres == WORD_ZERO);
          fl[FLAG_C] = prod16[WORD_MSB];
        end
        OP_RELATIVE_JUMP, OP_RELATIVE_SUBROUTINE_ENTRY: begin
          st_we_next = 1'b0;
          pc_we_next = 1'b1;
          pc_next = pc_rel; // RULE14 RULE17
          push_next = (op_in == OP_RELATIVE_SUBROUTINE_ENTRY); // RULE19
          push_data_next = pc_in + STEP_SHORT;
        end
        OP_INDIRECT_JUMP, OP_INDIRECT_SUBROUTINE_ENTRY: begin
          st_we_next = 1'b0;
          pc_we_next = 1'b1;
          pc_next = ptr_z_in; // RULE15 RULE18
          push_next = (op_in == OP_INDIRECT_SUBROUTINE_ENTRY); // RULE19
          push_data_next = pc_in + STEP_SHORT;
        end
        OP_ABSOLUTE_JUMP, OP_ABSOLUTE_SUBROUTINE_ENTRY: begin
          st_we_next = 1'b0;
          pc_we_next = 1'b1;
          pc_next = target_in; // RULE16
          push_next = (op_in == OP_ABSOLUTE_SUBROUTINE_ENTRY); // RULE19
          push_data_next = pc_in + STEP_LONG;
        end
        OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
          st_we_next = (op_in == OP_INTERRUPT_EXIT);
          fl[FLAG_I] = (op_in == OP_INTERRUPT_EXIT) | status_in[FLAG_I]; // RULE20
          pc_we_next = 1'b1;
          pc_next = stack_top_in; // RULE19
          pop_next = 1'b1;
        end
        default: st_we_next = 1'b0;
      endcase
      status_next = fl;
    end
  end

  // Registers only; every bit takes a constant under reset.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      count_reg <= CYC_ZERO;
      op_reg <= OP_ADD;
      rd_we_reg <= 1'b0;
      rd_data_reg <= BYTE_ZERO;
      pair_we_reg <= 1'b0;
      prod_we_reg <= 1'b0;
      pair_data_reg <= WORD_ZERO;
      st_we_reg <= 1'b0;
      status_reg <= STATUS_RST;
      pc_we_reg <= 1'b0;
      pc_reg <= '0;
      push_reg <= 1'b0;
      push_data_reg <= '0;
      pop_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      op_reg <= op_next;
      rd_we_reg <= rd_we_next;
      rd_data_reg <= rd_data_next;
      pair_we_reg <= pair_we_next;
      prod_we_reg <= prod_we_next;
      pair_data_reg <= pair_data_next;
      st_we_reg <= st_we_next;
      status_reg <= status_next;
      pc_we_reg <= pc_we_next;
      pc_reg <= pc_next;
      push_reg <= push_next;
      push_data_reg <= push_data_next;
      pop_reg <= pop_next;
    end
  end

  // Strobes are gated by done so that each write lasts exactly one cycle.
  assign busy_out = (state_reg == ST_BUSY);
  assign done_out = done;
  assign rd_we_out = done && rd_we_reg;
  assign pair_we_out = done && pair_we_reg;
  assign prod_we_out = done && prod_we_reg;
  assign status_we_out = done && st_we_reg;
  assign pc_we_out = done && pc_we_reg;
  assign push_out = done && push_reg;
  assign pop_out = done && pop_reg;
  assign rd_data_out = rd_data_reg;
  assign pair_data_out = pair_data_reg;
  assign status_out = status_reg;
  assign pc_out = pc_reg;
  assign push_data_out = push_data_reg;

  // Checks on latency and results.
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  a_add_one_cycle: assert property ( // RULE1
    accept && (op_in == OP_ADD) |=> done_out && rd_we_out && status_we_out &&
      (rd_data_out == $past(rd_val_in + rr_val_in)))
    else $error("register add did not finish in one cycle");
  a_sub_result: assert property ( // RULE2
    accept && (op_in == OP_SUB) |=> rd_data_out == $past(rd_val_in - rr_val_in))
    else $error("register subtract result wrong");
  a_imm_borrow: assert property ( // RULE3
    accept && (op_in == OP_MINUS_IMMEDIATE) |=> done_out &&
      (status_out[FLAG_C] == $past(rd_val_in < imm_in)))
    else $error("immediate subtract borrow wrong");
  a_word_two_cycles: assert property ( // RULE4 RULE5
    accept && (op_in inside {OP_WORD_IMMEDIATE_PLUS, OP_WORD_IMMEDIATE_MINUS})
      |=> !done_out ##1 done_out && pair_we_out)
    else $error("word operation not two cycles");
  a_logic_keeps_carry: assert property ( // RULE6
    accept && (op_in inside {OP_AND, OP_OR, OP_XOR_REGS, OP_MASK_IMMEDIATE})
      |=> (status_out[FLAG_C] == $past(status_in[FLAG_C])) && !status_out[FLAG_V])
    else $error("logic operation disturbed carry or overflow");
  a_invert_carry: assert property ( // RULE7
    accept && (op_in == OP_BITWISE_INVERT) |=> status_out[FLAG_C] &&
      (rd_data_out == ~$past(rd_val_in)))
    else $error("ones complement wrong");
  a_step_keeps_carry: assert property ( // RULE9
    accept && (op_in inside {OP_INC, OP_MINUS_ONE})
      |=> status_out[FLAG_C] == $past(status_in[FLAG_C]))
    else $error("increment or decrement changed carry");
  a_mul_product: assert property ( // RULE12
    accept && (op_in == OP_PRODUCT_UNSIGNED) |=> !done_out ##1 done_out && prod_we_out &&
      (pair_data_out == $past({8'h00, rd_val_in} * {8'h00, rr_val_in}, 2)))
    else $error("unsigned product wrong or late");
  a_rel_jump_pc: assert property ( // RULE14
    accept && (op_in == OP_RELATIVE_JUMP) |=> !done_out ##1 pc_we_out && !status_we_out)
    else $error("relative jump timing wrong");
  a_abs_entry_push: assert property ( // RULE16 RULE19
    accept && (op_in == OP_ABSOLUTE_SUBROUTINE_ENTRY)
      |=> !done_out [*3] ##1 done_out && push_out && pc_we_out)
    else $error("absolute entry not four cycles");
  a_exit_sets_enable: assert property ( // RULE20
    accept && (op_in == OP_INTERRUPT_EXIT)
      |=> !done_out [*3] ##1 pop_out && status_we_out && status_out[FLAG_I])
    else $error("interrupt exit did not set enable");
  a_ones_no_flags: assert property ( // RULE21
    accept && (op_in == OP_ALL_ONES_REGISTER) |=> rd_we_out && !status_we_out &&
      (rd_data_out == BYTE_ONES))
    else $error("all ones load wrong");

endmodule
`default_nettype wire

// [calje_core_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module calje_core_tb;
  import calje_pkg::*;
  logic clk, rst, start_q, ready, busy, done, rd_we, pair_we, prod_we, st_we, pc_we, push, pop;
  calje_op_e op_q;
  logic [7:0] rd_q, rr_q, st_q, rd_d, st_d;
  logic [15:0] pair_q, pair_d, pc, z_q, tgt_q, top, pc_d, push_d;
  logic [11:0] ofs_q;
  int miscompares = 0;
  int samples_checked = 0;
  // The constant K shares the Rr operand line to keep the stimulus small.
  calje_core calje_core_inst (.clock_in(clk), .sys_rst_in(rst), .start_in(start_q),
    .op_in(op_q), .ready_out(ready), .busy_out(busy), .done_out(done), .rd_val_in(rd_q),
    .rr_val_in(rr_q), .imm_in(rr_q), .pair_in(pair_q), .status_in(st_q), .pc_in(pc),
    .ptr_z_in(z_q), .rel_offset_in(ofs_q), .target_in(tgt_q), .stack_top_in(top),
    .rd_we_out(rd_we), .rd_data_out(rd_d), .pair_we_out(pair_we), .prod_we_out(prod_we),
    .pair_data_out(pair_d), .status_we_out(st_we), .status_out(st_d), .pc_we_out(pc_we),
    .pc_out(pc_d), .push_out(push), .push_data_out(push_d), .pop_out(pop));
  calje_pc_model calje_pc_model_inst (.clock_in(clk), .sys_rst_in(rst), .pc_we_in(pc_we),
    .pc_val_in(pc_d), .push_in(push), .push_val_in(push_d), .pop_in(pop), .pc_out(pc),
    .top_out(top));
  // Free-running 200 MHz core clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic finish_test();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Issues one request and leaves the bench inside the done cycle, counting cycles.
  task automatic go(input calje_op_e op, input logic [7:0] a, b, si, input int n);
    int c;
    @(posedge clk);
    #1;
    op_q = op;
    rd_q = a;
    rr_q = b;
    st_q = si;
    start_q = 1'b1;
    @(posedge clk);
    #1;
    start_q = 1'b0;
    c = 1;
    while (done !== 1'b1 && c < 8) begin
      @(posedge clk);
      #1;
      c++;
    end
    chk("cycles", 16'(n), 16'(c));
  endtask
  task automatic alu(input calje_op_e op, input logic [7:0] a, b, si, r, so);
    go(op, a, b, si, 1);
    chk("rd_we", 16'h0001, {15'h0000, rd_we});
    chk("rd_data", {8'h00, r}, {8'h00, rd_d});
    chk("status_we", {15'h0000, op != OP_ALL_ONES_REGISTER}, {15'h0000, st_we});
    if (op != OP_ALL_ONES_REGISTER) chk("status", {8'h00, so}, {8'h00, st_d});
  endtask
  task automatic w2(input calje_op_e op, input logic [15:0] p, input logic [7:0] a, b,
    input logic [1:0] we, input logic [15:0] r, input logic [7:0] so);
    pair_q = p;
    go(op, a, b, 8'h00, 2);
    chk("pair_prod_we", {14'h0000, we}, {14'h0000, pair_we, prod_we});
    chk("word", r, pair_d);
    chk("status", {8'h00, so}, {8'h00, st_d});
  endtask
  task automatic jmp(input calje_op_e op, input logic [15:0] zt, input logic [11:0] o,
    input int n, input logic [15:0] e, input logic [1:0] pp, input logic [15:0] pd);
    z_q = (op inside {OP_ABSOLUTE_JUMP, OP_ABSOLUTE_SUBROUTINE_ENTRY}) ? ~zt : zt;
    tgt_q = ~z_q;
    ofs_q = o;
    go(op, 8'h00, 8'h00, 8'h40, n);
    chk("pc_we", 16'h0001, {15'h0000, pc_we});
    chk("pc", e, pc_d);
    chk("push_pop", {14'h0000, pp}, {14'h0000, push, pop});
    if (pp[1]) chk("push_data", pd, push_d);
    chk("status_we", {15'h0000, op == OP_INTERRUPT_EXIT}, {15'h0000, st_we});
    if (op == OP_INTERRUPT_EXIT) chk("status", 16'h00C0, {8'h00, st_d});
    @(posedge clk);
    #1;
    chk("model_pc", e, pc);
  endtask
  // A request held high through a jump is refused, then taken in the done cycle.
  task automatic b2b();
    rd_q = 8'h01;
    rr_q = 8'h02;
    tgt_q = 16'h0042;
    op_q = OP_ABSOLUTE_JUMP;
    start_q = 1'b1;
    @(posedge clk);
    #1;
    op_q = OP_ADD;
    chk("ready_busy", 16'h0001, {14'h0000, ready, busy});
    repeat (2) @(posedge clk);
    #1;
    chk("jump_done", 16'h0006, {13'h0000, done, pc_we, rd_we});
    @(posedge clk);
    #1;
    start_q = 1'b0;
    chk("add_done", 16'h0002, {14'h0000, rd_we, pc_we});
    chk("add_sum", 16'h0003, {8'h00, rd_d});
  endtask
  // Main sequence; reset is held over two edges first.
  initial begin
    start_q = 1'b0;
    op_q = OP_ADD;
    {rd_q, rr_q, st_q, pair_q, z_q, tgt_q, ofs_q} = '0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("idle", 16'h0004, {13'h0000, ready, busy, done});
    alu(OP_ADD, 8'h7F, 8'h01, 8'h00, 8'h80, 8'h2C);
    alu(OP_ADC, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h23);
    alu(OP_SUB, 8'h00, 8'h01, 8'h00, 8'hFF, 8'h35);
    alu(OP_MINUS_WITH_BORROW_REGS, 8'h05, 8'h05, 8'h01, 8'hFF, 8'h35);
    alu(OP_MINUS_IMMEDIATE, 8'h80, 8'h01, 8'h00, 8'h7F, 8'h38);
    alu(OP_MINUS_WITH_BORROW_IMMEDIATE, 8'h10, 8'h0F, 8'h00, 8'h01, 8'h20);
    alu(OP_AND, 8'hF0, 8'h0F, 8'h01, 8'h00, 8'h03);
    alu(OP_MASK_IMMEDIATE, 8'hF0, 8'h80, 8'h01, 8'h80, 8'h15);
    alu(OP_OR, 8'h12, 8'h21, 8'h00, 8'h33, 8'h00);
    alu(OP_MERGE_IMMEDIATE, 8'h01, 8'h80, 8'h00, 8'h81, 8'h14);
    alu(OP_XOR_REGS, 8'hFF, 8'h0F, 8'h00, 8'hF0, 8'h14);
    alu(OP_BITWISE_INVERT, 8'h55, 8'h00, 8'h00, 8'hAA, 8'h15);
    alu(OP_TWOS_INVERT, 8'h80, 8'h00, 8'h00, 8'h80, 8'h0D);
    alu(OP_SET_BITS_MASKED, 8'h00, 8'h08, 8'h00, 8'h08, 8'h00);
    alu(OP_CLEAR_BITS_MASKED, 8'hA5, 8'h0F, 8'h00, 8'hA0, 8'h14);
    alu(OP_INC, 8'h7F, 8'h00, 8'h01, 8'h80, 8'h0D);
    alu(OP_MINUS_ONE, 8'h80, 8'h00, 8'h00, 8'h7F, 8'h18);
    alu(OP_ZERO_MINUS_CHECK, 8'h00, 8'h00, 8'h21, 8'h00, 8'h23);
    alu(OP_ZERO_REGISTER, 8'h5A, 8'h00, 8'h0C, 8'h00, 8'h02);
    alu(OP_ALL_ONES_REGISTER, 8'h12, 8'h00, 8'h3F, 8'hFF, 8'h00);
    w2(OP_WORD_IMMEDIATE_PLUS, 16'hFFFF, 8'h00, 8'h01, 2'b10, 16'h0000, 8'h03);
    w2(OP_WORD_IMMEDIATE_MINUS, 16'h0000, 8'h00, 8'h01, 2'b10, 16'hFFFF, 8'h15);
    w2(OP_PRODUCT_UNSIGNED, 16'h5A5A, 8'hFF, 8'hFF, 2'b01, 16'hFE01, 8'h01);
    w2(OP_PRODUCT_UNSIGNED, 16'h5A5A, 8'h00, 8'h37, 2'b01, 16'h0000, 8'h02);
    w2(OP_PRODUCT_SIGNED, 16'h5A5A, 8'hFF, 8'hFF, 2'b01, 16'h0001, 8'h00);
    w2(OP_PRODUCT_SIGNED_BY_UNSIGNED, 16'h5A5A, 8'hFF, 8'h02, 2'b01, 16'hFFFE, 8'h01);
    w2(OP_FRACTIONAL_PRODUCT_UNSIGNED, 16'h5A5A, 8'h80, 8'h80, 2'b01, 16'h8000, 8'h00);
    w2(OP_FRACTIONAL_PRODUCT_SIGNED, 16'h5A5A, 8'h80, 8'h80, 2'b01, 16'h8000, 8'h00);
    w2(OP_FRACTIONAL_PRODUCT_MIXED, 16'h5A5A, 8'h80, 8'h40, 2'b01, 16'hC000, 8'h01);
    jmp(OP_RELATIVE_JUMP, 16'h0000, 12'hFFE, 2, 16'h00FF, 2'b00, 16'h0000);
    jmp(OP_INDIRECT_JUMP, 16'h1234, 12'h000, 2, 16'h1234, 2'b00, 16'h0000);
    jmp(OP_ABSOLUTE_JUMP, 16'h0ABC, 12'h000, 3, 16'h0ABC, 2'b00, 16'h0000);
    jmp(OP_RELATIVE_SUBROUTINE_ENTRY, 16'h0000, 12'h010, 3, 16'h0ACD, 2'b10, 16'h0ABD);
    jmp(OP_INDIRECT_SUBROUTINE_ENTRY, 16'h2000, 12'h000, 3, 16'h2000, 2'b10, 16'h0ACE);
    jmp(OP_ABSOLUTE_SUBROUTINE_ENTRY, 16'h3000, 12'h000, 4, 16'h3000, 2'b10, 16'h2002);
    jmp(OP_SUBROUTINE_EXIT, 16'h0000, 12'h000, 4, 16'h2002, 2'b01, 16'h0000);
    jmp(OP_INTERRUPT_EXIT, 16'h0000, 12'h000, 4, 16'h0ACE, 2'b01, 16'h0000);
    b2b();
    finish_test();
  end
  // Cuts a hang short well beyond the hundred or so cycles the sequence needs.
  initial begin
    #20000;
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire

// [calje_pc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module calje_pc_model #(
  parameter int PC_W = 16,
  parameter logic [15:0] PC_RST = 16'h0100
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Strobes from the core
  input wire logic pc_we_in,
  input wire logic [PC_W-1:0] pc_val_in,
  input wire logic push_in,
  input wire logic [PC_W-1:0] push_val_in,
  input wire logic pop_in,
  // State seen by the core
  output logic [PC_W-1:0] pc_out,
  output logic [PC_W-1:0] top_out
);
  logic [PC_W-1:0] stack_mem [0:7];
  logic [2:0] sp_reg;
  // An empty stack shows a changing value, so a stray pop never reads a stale address.
  assign top_out = (sp_reg == 3'h0) ? ~pc_out : stack_mem[sp_reg - 3'h1];
  // Writes land on the edge that closes the core's done cycle.
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pc_out <= PC_RST[PC_W-1:0];
      sp_reg <= 3'h0;
    end else begin
      if (pc_we_in) begin
        pc_out <= pc_val_in;
      end
      if (push_in) begin
        stack_mem[sp_reg] <= push_val_in;
        sp_reg <= sp_reg + 3'h1;
      end else if (pop_in) begin
        sp_reg <= sp_reg - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [calje_pkg.sv]
`default_nettype none
package calje_pkg;

  // Bit positions in the core status byte.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Operand geometry of the 8-bit datapath.
  localparam int BYTE_MSB = 7;
  localparam int WORD_MSB = 15;
  localparam int NIB_W = 4;

  // Byte and word constants used by the datapath.
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;

  // Execution lengths in core clock cycles.
  localparam logic [2:0] CYC_ZERO = 3'h0;
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;

  // Program counter steps over a one-word and a two-word instruction.
  localparam int PC_STEP_SHORT = 1;
  localparam int PC_STEP_LONG = 2;

  // Operations executed by the block.
  typedef enum logic [5:0] {
    OP_ADD = 6'h00, OP_ADC = 6'h01, OP_WORD_IMMEDIATE_PLUS = 6'h02,
    OP_SUB = 6'h03, OP_MINUS_IMMEDIATE = 6'h04, OP_MINUS_WITH_BORROW_REGS = 6'h05,
    OP_MINUS_WITH_BORROW_IMMEDIATE = 6'h06, OP_WORD_IMMEDIATE_MINUS = 6'h07,
    OP_AND = 6'h08, OP_MASK_IMMEDIATE = 6'h09, OP_OR = 6'h0A, OP_MERGE_IMMEDIATE = 6'h0B,
    OP_XOR_REGS = 6'h0C, OP_BITWISE_INVERT = 6'h0D, OP_TWOS_INVERT = 6'h0E,
    OP_SET_BITS_MASKED = 6'h0F, OP_CLEAR_BITS_MASKED = 6'h10, OP_INC = 6'h11,
    OP_MINUS_ONE = 6'h12, OP_ZERO_MINUS_CHECK = 6'h13, OP_ZERO_REGISTER = 6'h14,
    OP_ALL_ONES_REGISTER = 6'h15, OP_PRODUCT_UNSIGNED = 6'h16, OP_PRODUCT_SIGNED = 6'h17,
    OP_PRODUCT_SIGNED_BY_UNSIGNED = 6'h18, OP_FRACTIONAL_PRODUCT_UNSIGNED = 6'h19,
    OP_FRACTIONAL_PRODUCT_SIGNED = 6'h1A, OP_FRACTIONAL_PRODUCT_MIXED = 6'h1B,
    OP_RELATIVE_JUMP = 6'h1C, OP_INDIRECT_JUMP = 6'h1D, OP_ABSOLUTE_JUMP = 6'h1E,
    OP_RELATIVE_SUBROUTINE_ENTRY = 6'h1F, OP_INDIRECT_SUBROUTINE_ENTRY = 6'h20,
    OP_ABSOLUTE_SUBROUTINE_ENTRY = 6'h21, OP_SUBROUTINE_EXIT = 6'h22,
    OP_INTERRUPT_EXIT = 6'h23
  } calje_op_e;

  // Sequencer states.
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_BUSY = 1'b1
  } calje_state_e;

endpackage
`default_nettype wire
